//--- logic/tlm_pkg.sv
// Package of constants and types for the trip log and status monitor.
// What this block does
// RL1 - Inhibited status, output off, without enable
// RL2 - Ready status, output off, no run
// RL3 - Stopped, supply loss, braking statuses enable output
// RL4 - Tripped status disables output, shows code
// RL5 - Undervoltage status disables output in both modes
// RL6 - Power-stage wait status until processor responds
// RL7 - Option wait status until module responds
// RL8 - Database status_database_a status during whole transfer
// RL9 - Ten trip codes, entry zero newest
// RL10 - New trip shifts log, oldest lost
// RL11 - Date and time logged with each trip
// RL12 - Sub-trip numbers logged, zero when none
// RL13 - Trip log reads return numeric trip number
// RL14 - Writing 255 to clear register resets logs
// RL15 - Any trip disables output immediately
// RL16 - Monitored quantities frozen until trip cleared
// RL17 - Bit 4 of trip action disables freezing
// RL18 - Trip held until reset, then live updates
package tlm_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int TLM_LOG_DEPTH  = 10;   // Entries in each trip log.
    localparam int TLM_MON_COUNT  = 18;   // Monitored quantities.
    localparam int TLM_MON_WIDTH  = 16;   // Width of one quantity.

    // ----------------------------------------------------------------
    // Register word offsets (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [7:0] TLM_IDX_STATUS    = 8'h00; // Drive status.
    localparam logic [7:0] TLM_IDX_CONTROL   = 8'h01; // Software enable.
    localparam logic [7:0] TLM_IDX_TRIP_ACT  = 8'h02; // Trip action.
    localparam logic [7:0] TLM_IDX_LOG_CLEAR = 8'h03; // Log clear.
    localparam logic [7:0] TLM_IDX_IRQ_STAT  = 8'h04; // Sticky events.
    localparam logic [7:0] TLM_IDX_IRQ_MASK  = 8'h05; // Event mask.
    localparam logic [7:0] TLM_IDX_TRIP0     = 8'h10; // Codes 10..19.
    localparam logic [7:0] TLM_IDX_DATE0     = 8'h20; // Dates 20..29.
    localparam logic [7:0] TLM_IDX_TIME0     = 8'h30; // Times 30..39.
    localparam logic [7:0] TLM_IDX_SUB0      = 8'h40; // Subtrips 40..49.
    localparam logic [7:0] TLM_IDX_MON0      = 8'h50; // Monitors 50..61.

    // ----------------------------------------------------------------
    // Field positions and values
    // ----------------------------------------------------------------
    localparam int         TLM_BIT_NO_FREEZE = 4;      // Trip action bit.
    localparam logic [7:0] TLM_CLEAR_CODE    = 8'hff;  // Log clear value.
    localparam int         TLM_BIT_SW_EN     = 0;      // Control enable.
    localparam logic [31:0] TLM_CONTROL_RST  = 32'h0000_0001;
    localparam int         TLM_EV_TRIP       = 0;      // Event: new trip.
    localparam int         TLM_EV_CLEARED    = 1;      // Event: trip reset.
    localparam int         TLM_EV_STATUS     = 2;      // Event: status moved.
    localparam int         TLM_EV_COUNT      = 3;

    // ----------------------------------------------------------------
    // Status codes shown to the display and to software
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        TLM_ST_INHIBIT,
        TLM_ST_READY,
        TLM_ST_STOPPED,
        TLM_ST_SUPPLY_LOSS,
        TLM_ST_DC_BRAKING,
        TLM_ST_TRIPPED,
        TLM_ST_UNDERVOLTAGE,
        TLM_ST_RUN,
        TLM_ST_POWER_STAGE_WAIT,
        TLM_ST_OPTION_WAIT,
        TLM_ST_DATABASE_LOAD
    } tlm_status_t;

    // Power-up sequence states.
    typedef enum logic [1:0] {
        TLM_PU_POWER_STAGE,
        TLM_PU_OPTION,
        TLM_PU_DATABASE,
        TLM_PU_DONE
    } tlm_powerup_t;

endpackage : tlm_pkg

//--- logic/tlm_monitor.sv
// Drive status encoder, trip log and trip freeze logic with Wishbone slave.
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
module tlm_monitor
    import tlm_pkg::*;
#(
    parameter int CODE_W = 8,              // Width of a trip code.
    parameter int SUB_W  = 8               // Width of a sub-trip number.
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // Wishbone classic slave.
    input  wire logic                     cyc_i,
    input  wire logic                     stb_i,
    input  wire logic                     we_i,
    input  wire logic [9:0]               adr_i,
    input  wire logic [3:0]               sel_i,
    input  wire logic [31:0]              dat_i,
    output logic      [31:0]              dat_o,
    output logic                          ack_o,
    // Drive conditions.
    input  wire logic                     hw_enable_i,
    input  wire logic                     run_cmd_i,
    input  wire logic                     at_zero_speed_i,
    input  wire logic                     supply_loss_i,
    input  wire logic                     dc_braking_i,
    input  wire logic                     undervoltage_i,
    input  wire logic                     power_stage_ready_i,
    input  wire logic                     option_ready_i,
    input  wire logic                     db_status_database_a_needed_i,
    input  wire logic                     db_status_database_a_busy_i,
    // Trip sources.
    input  wire logic                     trip_i,
    input  wire logic [CODE_W-1:0]        trip_code_i,
    input  wire logic                     trip_has_sub_i,
    input  wire logic [SUB_W-1:0]         trip_sub_i,
    input  wire logic                     trip_reset_i,
    input  wire logic [31:0]              date_i,
    input  wire logic [31:0]              time_i,
    // Live monitored quantities, packed one after another.
    input  wire logic [TLM_MON_COUNT*TLM_MON_WIDTH-1:0] mon_live_i,
    // Outputs.
    output logic                          output_enable_o,
    output logic [3:0]                    status_o,
    output logic [CODE_W-1:0]             display_trip_code_o,
    output logic                          irq_o
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [CODE_W-1:0]  trip_log [TLM_LOG_DEPTH];   // Codes, 0 newest.
    logic [31:0]        date_log [TLM_LOG_DEPTH];   // Trip dates.
    logic [31:0]        time_log [TLM_LOG_DEPTH];   // Trip times.
    logic [SUB_W-1:0]   sub_log  [TLM_LOG_DEPTH];   // Sub-trip numbers.
    logic [TLM_MON_WIDTH-1:0] mon_held [TLM_MON_COUNT]; // Shown values.
    logic               tripped;                    // Trip latched.
    logic               sw_enable;                  // Software enable.
    logic [31:0]        trip_action;                // Trip action word.
    logic [TLM_EV_COUNT-1:0] irq_stat;              // Sticky events.
    logic [TLM_EV_COUNT-1:0] irq_mask;              // Event mask.
    tlm_powerup_t       pu_state;                   // Power-up sequence.
    tlm_status_t        status;                     // Decoded status.
    tlm_status_t        status_last;                // Previous status.
    logic               new_trip;                   // First trip edge.
    logic               bus_req;                    // Access pending.
    logic               wr_go;                      // Write this edge.
    logic [7:0]         idx;                        // Word index.
    logic               log_clear;                  // Log wipe strobe.
    logic               freeze;                     // Hold monitors.
    logic [31:0]        next_dat;                   // Read mux result.
    logic [TLM_EV_COUNT-1:0] irq_set;               // Events this cycle.
    logic [TLM_EV_COUNT-1:0] irq_clr;               // Bits cleared now.

    // A trip is only logged once; a held trip_i does not refill the log.
    assign new_trip = trip_i && !tripped;
    assign bus_req  = cyc_i && stb_i && !ack_o;
    assign wr_go    = bus_req && we_i;
    assign idx      = adr_i[9:2];
    // Only the low byte carries the clear code, so lane 0 must be enabled.
    assign log_clear = wr_go && (idx == TLM_IDX_LOG_CLEAR) && sel_i[0]
                       && (dat_i[7:0] == TLM_CLEAR_CODE);       // [RL14]
    assign freeze = tripped && !trip_action[TLM_BIT_NO_FREEZE]; // [RL17]

    // True when idx falls in base..base+9, the word indices of one log.
    function automatic logic in_log(input logic [7:0] a,
                                    input logic [7:0] base);
        in_log = (a >= base) && (a < base + 8'(TLM_LOG_DEPTH));
    endfunction : in_log

    // Merge write data into a register under byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = be[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction : merge

    // ----------------------------------------------------------------
    // Power-up sequence
    // ----------------------------------------------------------------
    // Wait for the power stage, then the option module, then any status_database_a.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pu_state <= TLM_PU_POWER_STAGE;
        end else begin
            case (pu_state)
                TLM_PU_POWER_STAGE: begin
                    if (power_stage_ready_i) begin            // [RL6]
                        pu_state <= TLM_PU_OPTION;
                    end
                end
                TLM_PU_OPTION: begin
                    if (option_ready_i) begin                 // [RL7]
                        pu_state <= db_status_database_a_needed_i ? TLM_PU_DATABASE
                                                       : TLM_PU_DONE;
                    end
                end
                TLM_PU_DATABASE: begin
                    if (!db_status_database_a_busy_i) begin              // [RL8]
                        pu_state <= TLM_PU_DONE;
                    end
                end
                default: begin
                    pu_state <= TLM_PU_DONE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Status decode
    // ----------------------------------------------------------------
    // Priority: power-up waits, trip, undervoltage, inhibit, ready, run.
    always_comb begin
        case (pu_state)
            TLM_PU_POWER_STAGE: status = TLM_ST_POWER_STAGE_WAIT; // [RL6]
            TLM_PU_OPTION:      status = TLM_ST_OPTION_WAIT;      // [RL7]
            TLM_PU_DATABASE:    status = TLM_ST_DATABASE_LOAD;    // [RL8]
            default: begin
                if (tripped || trip_i) begin
                    status = TLM_ST_TRIPPED;                      // [RL4]
                end else if (undervoltage_i) begin
                    status = TLM_ST_UNDERVOLTAGE;                 // [RL5]
                end else if (!hw_enable_i || !sw_enable) begin
                    status = TLM_ST_INHIBIT;                      // [RL1]
                end else if (!run_cmd_i) begin
                    status = TLM_ST_READY;                        // [RL2]
                end else if (dc_braking_i) begin
                    status = TLM_ST_DC_BRAKING;                   // [RL3]
                end else if (supply_loss_i) begin
                    status = TLM_ST_SUPPLY_LOSS;                  // [RL3]
                end else if (at_zero_speed_i) begin
                    status = TLM_ST_STOPPED;                      // [RL3]
                end else begin
                    status = TLM_ST_RUN;
                end
            end
        endcase
    end

    // Output stage follows the status; trip_i acts in the same cycle.
    always_comb begin
        case (status)
            TLM_ST_STOPPED, TLM_ST_SUPPLY_LOSS,
            TLM_ST_DC_BRAKING, TLM_ST_RUN: output_enable_o = 1'b1; // [RL3]
            default: output_enable_o = 1'b0;          // [RL1] [RL2] [RL15]
        endcase
    end

    assign status_o = status;

    // ----------------------------------------------------------------
    // Trip latch and display code
    // ----------------------------------------------------------------
    // The trip stays latched until a reset request; a fresh trip wins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tripped             <= 1'b0;
            display_trip_code_o <= '0;
        end else if (new_trip) begin
            tripped             <= 1'b1;
            display_trip_code_o <= trip_code_i;                   // [RL4]
        end else if (trip_reset_i) begin
            tripped             <= 1'b0;                          // [RL18]
        end
    end

    // ----------------------------------------------------------------
    // Trip logs
    // ----------------------------------------------------------------
    // All four logs shift together; a clear request empties them.
    always_ff @(posedge clk_i) begin
        if (rst_i || log_clear) begin                             // [RL14]
            for (int i = 0; i < TLM_LOG_DEPTH; i++) begin
                trip_log[i] <= '0;
                date_log[i] <= '0;
                time_log[i] <= '0;
                sub_log[i]  <= '0;
            end
        end else if (new_trip) begin
            for (int i = TLM_LOG_DEPTH-1; i > 0; i--) begin       // [RL10]
                trip_log[i] <= trip_log[i-1];
                date_log[i] <= date_log[i-1];                     // [RL11]
                time_log[i] <= time_log[i-1];
                sub_log[i]  <= sub_log[i-1];                      // [RL12]
            end
            trip_log[0] <= trip_code_i;                           // [RL9]
            date_log[0] <= date_i;                                // [RL11]
            time_log[0] <= time_i;
            sub_log[0]  <= trip_has_sub_i ? trip_sub_i : '0;      // [RL12]
        end
    end

    // ----------------------------------------------------------------
    // Monitored quantities
    // ----------------------------------------------------------------
    // Held values track live inputs except while a trip freezes them.
    // Freezing starts the edge after the trip, so the held copy shows
    // the values of the trip cycle itself.
    generate
        for (genvar m = 0; m < TLM_MON_COUNT; m++) begin : g_mon
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    mon_held[m] <= '0;
                end else if (!freeze) begin                // [RL16] [RL18]
                    mon_held[m] <= mon_live_i[m*TLM_MON_WIDTH +:
                                              TLM_MON_WIDTH];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Software enable and trip action word, written with byte lanes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_enable   <= TLM_CONTROL_RST[TLM_BIT_SW_EN];
            trip_action <= '0;
        end else if (wr_go) begin
            if (idx == TLM_IDX_CONTROL && sel_i[0]) begin
                sw_enable <= dat_i[TLM_BIT_SW_EN];                // [RL1]
            end
            if (idx == TLM_IDX_TRIP_ACT) begin
                trip_action <= merge(trip_action, dat_i, sel_i);  // [RL17]
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    // Events of this cycle and the bits that software clears in it.
    // Kept apart so that the register process below stays non-blocking.
    always_comb begin
        irq_set = '0;
        irq_clr = '0;
        irq_set[TLM_EV_TRIP]    = new_trip;
        irq_set[TLM_EV_CLEARED] = tripped && trip_reset_i && !new_trip;
        irq_set[TLM_EV_STATUS]  = (status != status_last);
        if (wr_go && idx == TLM_IDX_IRQ_STAT && sel_i[0]) begin
            irq_clr = dat_i[TLM_EV_COUNT-1:0];
        end
    end

    // Sticky events, write one to clear; a new event wins over the clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat    <= '0;
            irq_mask    <= '0;
            status_last <= TLM_ST_POWER_STAGE_WAIT;
        end else begin
            irq_stat    <= (irq_stat & ~irq_clr) | irq_set;
            status_last <= status;
            if (wr_go && idx == TLM_IDX_IRQ_MASK && sel_i[0]) begin
                irq_mask <= dat_i[TLM_EV_COUNT-1:0];
            end
        end
    end

    assign irq_o = |(irq_stat & irq_mask);

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Log codes read back as plain trip numbers; unmapped words read 0.
    always_comb begin
        next_dat = '0;
        if (idx == TLM_IDX_STATUS) begin
            next_dat[3:0] = status;
            next_dat[4]   = output_enable_o;
            next_dat[5]   = tripped;
        end else if (idx == TLM_IDX_CONTROL) begin
            next_dat[TLM_BIT_SW_EN] = sw_enable;
        end else if (idx == TLM_IDX_TRIP_ACT) begin
            next_dat = trip_action;
        end else if (idx == TLM_IDX_IRQ_STAT) begin
            next_dat[TLM_EV_COUNT-1:0] = irq_stat;
        end else if (idx == TLM_IDX_IRQ_MASK) begin
            next_dat[TLM_EV_COUNT-1:0] = irq_mask;
        end else if (in_log(idx, TLM_IDX_TRIP0)) begin
            next_dat[CODE_W-1:0] = trip_log[4'(idx - TLM_IDX_TRIP0)]; // [RL13]
        end else if (in_log(idx, TLM_IDX_DATE0)) begin
            next_dat = date_log[4'(idx - TLM_IDX_DATE0)];
        end else if (in_log(idx, TLM_IDX_TIME0)) begin
            next_dat = time_log[4'(idx - TLM_IDX_TIME0)];
        end else if (in_log(idx, TLM_IDX_SUB0)) begin
            next_dat[SUB_W-1:0] = sub_log[4'(idx - TLM_IDX_SUB0)];
        end else if (idx >= TLM_IDX_MON0 &&
                     idx < TLM_IDX_MON0 + 8'(TLM_MON_COUNT)) begin
            next_dat[TLM_MON_WIDTH-1:0] =
                mon_held[5'(idx - TLM_IDX_MON0)];
        end
    end

    // One wait-free answer: ack the edge after the request, then drop.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end else begin
            ack_o <= bus_req;
            if (bus_req && !we_i) begin
                dat_o <= next_dat;
            end
        end
    end

endmodule : tlm_monitor

//--- verif/tlm_monitor_props.sv
// Concurrent checks on the ports of the trip log and status monitor.
`timescale 1ns/1ps
module tlm_monitor_props (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       trip_i,
    input wire logic       trip_reset_i,
    input wire logic       power_stage_ready_i,
    input wire logic       option_ready_i,
    input wire logic       output_enable_o,
    input wire logic [3:0] status_o
);
    // ------------------------------------------------------------
    // One clock domain, so one default clock and disable.
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    inhibit_oe_a : assert property (
        status_o == 4'h0 |-> !output_enable_o)
        else $error("Output stage on while inhibited.");
    ready_oe_a : assert property (
        status_o == 4'h1 |-> !output_enable_o)
        else $error("Output stage on while ready.");
    active_oe_a : assert property (
        status_o inside {4'h2, 4'h3, 4'h4} |-> output_enable_o)
        else $error("Output stage off in an active state.");
    tripped_oe_a : assert property (
        status_o == 4'h5 |-> !output_enable_o)
        else $error("Output stage on while tripped.");
    undervolt_oe_a : assert property (
        status_o == 4'h6 |-> !output_enable_o)
        else $error("Output stage on in undervoltage.");
    // A trip outside power-up disables the stage in its own cycle.
    trip_entry_a : assert property (
        trip_i && status_o < 4'h8
        |-> status_o == 4'h5 && !output_enable_o)
        else $error("Trip did not disable the output at once.");
    trip_hold_a : assert property (
        status_o == 4'h5 && !trip_reset_i |=> status_o == 4'h5)
        else $error("Trip left without a reset.");
    reset_status_a : assert property (
        $fell(rst_i) |-> status_o == 4'h8)
        else $error("Power-stage wait not shown after reset.");
    ps_wait_a : assert property (
        status_o == 4'h8 && !power_stage_ready_i |=> status_o == 4'h8)
        else $error("Power-stage wait left too early.");
    opt_wait_a : assert property (
        status_o == 4'h9 && !option_ready_i |=> status_o == 4'h9)
        else $error("Option wait left too early.");
endmodule : tlm_monitor_props

//--- verif/tlm_panel_model.sv
// Front-panel display model that shows the code of a latched trip.
`timescale 1ns/1ps
module tlm_panel_model
    import tlm_pkg::*;
(
    input  wire logic [3:0] status_i,
    input  wire logic [7:0] code_i,
    output logic      [7:0] shown_o
);
    // The panel blanks the code unless the drive reports a trip.
    assign shown_o = status_i == 4'(TLM_ST_TRIPPED) ? code_i : 8'h00;
endmodule : tlm_panel_model

//--- verif/tlm_testbench.sv
// Self-checking bench for the trip log and status monitor.
`timescale 1ns/1ps
module testbench;
    import tlm_pkg::*;
    // ------------------------------------------------------------
    // Stimulus signals, each given a value at time zero, and observed signals.
    // ------------------------------------------------------------
    logic        clk_i = 1'b0, rst_i = 1'b1;
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [9:0]  adr_i = 10'h0;
    logic [3:0]  sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, date_i = 32'h0, time_i = 32'h0;
    logic        ack_o, output_enable_o, irq_o;
    logic        hw_enable_i = 1'b0, run_cmd_i = 1'b0;
    logic        at_zero_speed_i = 1'b0, supply_loss_i = 1'b0;
    logic        dc_braking_i = 1'b0, undervoltage_i = 1'b0;
    logic        power_stage_ready_i = 1'b0, option_ready_i = 1'b0;
    logic        db_status_database_a_needed_i = 1'b0, db_status_database_a_busy_i = 1'b0;
    logic        trip_i = 1'b0, trip_has_sub_i = 1'b0;
    logic        trip_reset_i = 1'b0;
    logic [7:0]  trip_code_i = 8'h0, trip_sub_i = 8'h0;
    logic [TLM_MON_COUNT*TLM_MON_WIDTH-1:0] mon_live_i = '0;
    logic [3:0]  status_o;
    logic [7:0]  display_trip_code_o, shown;
    logic [31:0] q, c;
    int          mismatches = 0, samples_checked = 0;
    // Rows: enable, run, zero speed, supply loss, braking, undervoltage,
    // then the expected status and output-stage level.
    logic [10:0] rows [6] = '{11'b000000_0000_0, 11'b100000_0001_0,
        11'b111000_0010_1, 11'b110100_0011_1, 11'b110010_0100_1,
        11'b110001_0110_0};

    always #12.5 clk_i = ~clk_i;
    tlm_monitor dut (.*);
    tlm_panel_model u_panel (.status_i(status_o),
        .code_i(display_trip_code_o), .shown_o(shown));

    task automatic summarize;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] idx,
                      input logic [31:0] d, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {idx, 2'b00};
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            summarize();
        end
    endtask : wb

    // Status is combinational, so it is read at the falling edge.
    task automatic wait_st(input logic [3:0] exp);
        int n;
        n = 0;
        while (status_o !== exp && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        chk(32'(status_o), 32'(exp));
        if (n >= 100) summarize();
    endtask : wait_st

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, TLM_IDX_STATUS, 32'h0, q);
        chk(q & 32'h1f, 32'h8);
        @(posedge clk_i);
        power_stage_ready_i <= 1'b1;
        wait_st(4'h9);
        @(posedge clk_i);
        db_status_database_a_needed_i <= 1'b1;
        db_status_database_a_busy_i   <= 1'b1;
        option_ready_i     <= 1'b1;
        wait_st(4'ha);
        wb(1'b0, TLM_IDX_STATUS, 32'h0, q);
        chk(q & 32'hf, 32'ha);
        db_status_database_a_busy_i <= 1'b0;
        foreach (rows[r]) begin
            @(posedge clk_i);
            {hw_enable_i, run_cmd_i, at_zero_speed_i, supply_loss_i,
             dc_braking_i, undervoltage_i} <= rows[r][10:5];
            wait_st(rows[r][4:1]);
            chk(32'(output_enable_o), 32'(rows[r][0]));
        end
        @(posedge clk_i);
        undervoltage_i <= 1'b0;
        wait_st(4'h7);
        wb(1'b1, TLM_IDX_CONTROL, 32'h0, q);
        wait_st(4'h0);
        wb(1'b1, TLM_IDX_CONTROL, 32'h1, q);
        wait_st(4'h7);
        // Eleven trips push the first one out of the ten-deep log.
        for (int i = 1; i <= 11; i++) begin
            if (i == 11) wb(1'b1, TLM_IDX_TRIP_ACT, 32'h10, q);
            @(posedge clk_i);
            trip_code_i    <= 8'(i);
            date_i         <= 32'h100 + i;
            time_i         <= 32'h200 + i;
            trip_has_sub_i <= i[0];
            trip_sub_i     <= 8'h30 + 8'(i);
            mon_live_i     <= {TLM_MON_COUNT{16'h1111}};
            trip_i         <= 1'b1;
            @(posedge clk_i);
            trip_i     <= 1'b0;
            mon_live_i <= {TLM_MON_COUNT{16'h2200 + 16'(i)}};
            // The trip edge launches the code; look once it has settled.
            @(negedge clk_i);
            wait_st(4'h5);
            chk(32'(output_enable_o), 32'h0);
            chk(32'(display_trip_code_o), 32'(i));
            chk(32'(shown), 32'(i));
            wb(1'b0, TLM_IDX_MON0, 32'h0, q);
            chk(q & 32'hffff, i == 11 ? 32'h2200 + i : 32'h1111);
            @(posedge clk_i);
            trip_reset_i <= 1'b1;
            @(posedge clk_i);
            trip_reset_i <= 1'b0;
            wait_st(4'h7);
            wb(1'b0, TLM_IDX_MON0, 32'h0, q);
            chk(q & 32'hffff, 32'h2200 + i);
        end
        for (int k = 0; k < 10; k++) begin
            c = 11 - k;
            wb(1'b0, TLM_IDX_TRIP0 + 8'(k), 32'h0, q);
            chk(q, c);
            wb(1'b0, TLM_IDX_DATE0 + 8'(k), 32'h0, q);
            chk(q, 32'h100 + c);
            wb(1'b0, TLM_IDX_TIME0 + 8'(k), 32'h0, q);
            chk(q, 32'h200 + c);
            wb(1'b0, TLM_IDX_SUB0 + 8'(k), 32'h0, q);
            chk(q, c[0] ? 32'h30 + c : 32'h0);
        end
        chk(32'(irq_o), 32'h0);
        wb(1'b1, TLM_IDX_IRQ_MASK, 32'h1, q);
        chk(32'(irq_o), 32'h1);
        wb(1'b1, TLM_IDX_IRQ_STAT, 32'h1, q);
        chk(32'(irq_o), 32'h0);
        wb(1'b1, TLM_IDX_LOG_CLEAR, 32'hfe, q);
        wb(1'b0, TLM_IDX_TRIP0, 32'h0, q);
        chk(q, 32'hb);
        wb(1'b1, TLM_IDX_LOG_CLEAR, 32'(TLM_CLEAR_CODE), q);
        wb(1'b0, TLM_IDX_DATE0 + 8'h9, 32'h0, q);
        chk(q, 32'h0);
        wb(1'b0, 8'hf0, 32'h0, q);
        chk(q, 32'h0);
        summarize();
    end
endmodule : testbench

bind tlm_monitor tlm_monitor_props u_props (.clk_i(clk_i), .rst_i(rst_i),
    .trip_i(trip_i), .trip_reset_i(trip_reset_i),
    .power_stage_ready_i(power_stage_ready_i),
    .option_ready_i(option_ready_i),
    .output_enable_o(output_enable_o), .status_o(status_o));
